/* File: odsc_pkg.sv */
// Package of register map, field layout and encodings for the driver B sync control block
package odsc_pkg;
  localparam logic [15:0] ADDR_DRIVER_B_CONFIG = 16'h14D8;
  localparam logic [15:0] ADDR_SECONDARY_CLOCK_PATH = 16'h14D9;
  localparam logic [15:0] ADDR_SYNC_CONTROL = 16'h14DB;
  localparam logic [15:0] ADDR_SYNC_COMMAND = 16'h14DC;
  localparam logic [15:0] ADDR_SYNC_STATUS = 16'h14DD;
  localparam logic [7:0] RESET_DRIVER_B_CONFIG = 8'h00;
  localparam logic [7:0] RESET_SECONDARY_CLOCK_PATH = 8'h00;
  localparam logic [7:0] RESET_SYNC_CONTROL = 8'h00;
  localparam int BIT_BYPASS_MUTE_RETIME = 5;
  localparam int BIT_DRIVER_MODE_HI = 4;
  localparam int BIT_DRIVER_MODE_LO = 3;
  localparam int BIT_DRIVE_CURRENT_HI = 2;
  localparam int BIT_DRIVE_CURRENT_LO = 1;
  localparam int BIT_HCSL_ENABLE = 0;
  localparam int BIT_SYSTEM_CLOCK_SOURCE_TO_DIV_B = 2;
  localparam int BIT_SYSTEM_CLOCK_SOURCE_TO_DIV_A = 1;
  localparam int BIT_SYSTEM_CLOCK_SOURCE_SYNC_MASK = 0;
  localparam int BIT_REF_SYNC_ENABLE = 2;
  localparam int BIT_AUTOSYNC_HI = 1;
  localparam int BIT_AUTOSYNC_LO = 0;
  localparam int BIT_SYNC_CMD = 0;
  localparam logic [7:0] MASK_DRIVER_B_CONFIG = 8'h3F;
  localparam logic [7:0] MASK_SECONDARY_CLOCK_PATH = 8'h07;
  localparam logic [7:0] MASK_SYNC_CONTROL = 8'h07;
  localparam int RETIME_CYCLES = 2;
  typedef enum logic [1:0] {
    ODSC_MODE_DIFF = 2'h0,
    ODSC_MODE_SE_ONE_DIV = 2'h1,
    ODSC_MODE_SE_TWO_DIV = 2'h2
  } odsc_mode_e;
  typedef enum logic [1:0] {
    ODSC_AUTO_MANUAL = 2'h0,
    ODSC_AUTO_ANALOG_OUTPUT_PLL = 2'h1,
    ODSC_AUTO_PHASE = 2'h2,
    ODSC_AUTO_FREQ = 2'h3
  } odsc_autosync_e;
  typedef enum logic [2:0] {
    ODSC_ST_IDLE = 3'h1,
    ODSC_ST_ARMED = 3'h2,
    ODSC_ST_RUN = 3'h4
  } odsc_state_e;
endpackage

/* File: odsc_sync_if.sv */
// Interface carrying lock inputs and the sync event between the top and the sync engine
`timescale 1ns/1ps
interface odsc_sync_if;
  logic [1:0] autosync_mode;
  logic manual_cmd;
  logic analog_output_pll_lock;
  logic phase_lock;
  logic freq_lock;
  logic sync_event;
  logic synced;
  modport top (output autosync_mode, output manual_cmd, output analog_output_pll_lock, output phase_lock,
    output freq_lock, input sync_event, input synced);
  modport engine (input autosync_mode, input manual_cmd, input analog_output_pll_lock, input phase_lock,
    input freq_lock, output sync_event, output synced);
endinterface

/* File: odsc_sync_engine.sv */
// Autosync policy: picks a lock source and issues one sync event per rising edge
`timescale 1ns/1ps
module odsc_sync_engine (
  input wire logic sys_clk,
  input wire logic rst,
  odsc_sync_if.engine sif
);
  logic sel_lock;
  logic sel_lock_reg;
  logic event_reg;
  logic synced_reg;

  always_comb begin
    unique case (sif.autosync_mode)
      odsc_pkg::ODSC_AUTO_MANUAL: sel_lock = 1'b0;
      odsc_pkg::ODSC_AUTO_ANALOG_OUTPUT_PLL: sel_lock = sif.analog_output_pll_lock;
      odsc_pkg::ODSC_AUTO_PHASE: sel_lock = sif.phase_lock;
      odsc_pkg::ODSC_AUTO_FREQ: sel_lock = sif.freq_lock;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_lock_reg <= 1'b0;
    end else begin
      sel_lock_reg <= sel_lock;
    end
  end

  // One pulse per rising edge; a held lock never retriggers while the autosync mode stays the same
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= sif.manual_cmd | (sel_lock & ~sel_lock_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      synced_reg <= 1'b0;
    end else if (event_reg) begin
      synced_reg <= 1'b1;
    end
  end

  assign sif.sync_event = event_reg;
  assign sif.synced = synced_reg;

  a_auto_edge_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    (sel_lock && !sel_lock_reg) |=> event_reg)
    else $error("auto sync edge missed");
  a_manual_no_auto: assert property (@(posedge sys_clk) disable iff (rst)
    (sif.autosync_mode == 2'h0 && !sif.manual_cmd) |=> !event_reg)
    else $error("auto sync in manual mode");
  a_held_no_repeat: assert property (@(posedge sys_clk) disable iff (rst)
    (sel_lock_reg && sel_lock && !sif.manual_cmd) |=> !event_reg)
    else $error("held lock retriggered");
endmodule

/* File: odsc_top.sv */
// Driver B configuration and output sync control top level with register port
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
// How it works
// - Mute is retimed by default; bypass bit mutes without the retiming hold.
// - Mode field picks differential, single-ended one divider, or two dividers.
// - Current field picks 7.5, 12.5 or 15 mA for both pins.
// - Style bit clear means CML, set means HCSL.
// - B path bit feeds buffered system clock into divider B.
// - A path bit feeds buffered system clock into divider A.
// - Sync mask bit blocks sync events on system clock outputs.
// - Reference sync bit enables automatic reference sync for the digital PLL.
// - Drivers stay static until a sync event has arrived.
// - Autosync 0 means no automatic sync; software issues the command.
// - Autosync 1 syncs on analog PLL lock.
// - Autosync 2 syncs on digital PLL phase lock.
// - Autosync 3 syncs on digital PLL frequency lock.
module odsc_top #(
  parameter int RETIME_CYCLES = odsc_pkg::RETIME_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mute_req,
  input wire logic analog_output_pll_lock_pin,
  input wire logic phase_lock_pin,
  input wire logic freq_lock_pin,
  input wire logic div_a_is_system_clock_source,
  input wire logic div_b_is_system_clock_source,
  output logic chan1_driver_b_output_mute,
  output logic chan1_driver_b_output_enable,
  output logic chan1_driver_b_output_hcsl,
  output logic [1:0] chan1_driver_b_output_current,
  output logic [1:0] chan1_driver_b_output_mode,
  output logic chan1_divider_b_enable,
  output logic chan1_divider_b_complement_enable,
  output logic chan1_divider_a_system_clock_source_sel,
  output logic chan1_divider_b_system_clock_source_sel,
  output logic chan1_divider_a_sync,
  output logic chan1_divider_b_sync,
  output logic channel1_digital_pll_ref_sync_en
);
  logic [7:0] drv_cfg_reg;
  logic [7:0] sec_path_reg;
  logic [7:0] sync_ctl_reg;
  logic [7:0] rdata_reg;
  logic manual_cmd_reg;
  logic [2:0] lock_meta_reg;
  logic [2:0] lock_sync_reg;
  logic mute_meta_reg;
  logic mute_sync_reg;
  logic [7:0] mute_cnt_reg;
  logic mute_retimed_reg;
  logic mute_out_reg;
  logic en_out_reg;
  logic hcsl_reg;
  logic [1:0] cur_reg;
  logic [1:0] mode_reg;
  logic divb_en_reg;
  logic divbb_en_reg;
  logic sela_reg;
  logic selb_reg;
  logic synca_reg;
  logic syncb_reg;
  logic refsync_reg;
  logic bypass;
  logic system_clock_source_mask;
  odsc_pkg::odsc_state_e state_reg;
  odsc_pkg::odsc_state_e state_next;

  odsc_sync_if sif ();

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    return a == target;
  endfunction

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drv_cfg_reg <= odsc_pkg::RESET_DRIVER_B_CONFIG;
      sec_path_reg <= odsc_pkg::RESET_SECONDARY_CLOCK_PATH;
      sync_ctl_reg <= odsc_pkg::RESET_SYNC_CONTROL;
    end else if (reg_wr) begin
      if (hit(reg_addr, odsc_pkg::ADDR_DRIVER_B_CONFIG)) begin
        drv_cfg_reg <= reg_wdata & odsc_pkg::MASK_DRIVER_B_CONFIG;
      end
      if (hit(reg_addr, odsc_pkg::ADDR_SECONDARY_CLOCK_PATH)) begin
        sec_path_reg <= reg_wdata & odsc_pkg::MASK_SECONDARY_CLOCK_PATH;
      end
      if (hit(reg_addr, odsc_pkg::ADDR_SYNC_CONTROL)) begin
        sync_ctl_reg <= reg_wdata & odsc_pkg::MASK_SYNC_CONTROL;
      end
    end
  end

  // Self-clearing manual sync command
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      manual_cmd_reg <= 1'b0;
    end else begin
      manual_cmd_reg <= reg_wr && hit(reg_addr, odsc_pkg::ADDR_SYNC_COMMAND)
        && reg_wdata[odsc_pkg::BIT_SYNC_CMD];
    end
  end

  // Read data one cycle after the strobe, zero elsewhere and for unmapped addresses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, odsc_pkg::ADDR_DRIVER_B_CONFIG)) begin
        rdata_reg <= drv_cfg_reg;
      end else if (hit(reg_addr, odsc_pkg::ADDR_SECONDARY_CLOCK_PATH)) begin
        rdata_reg <= sec_path_reg;
      end else if (hit(reg_addr, odsc_pkg::ADDR_SYNC_CONTROL)) begin
        rdata_reg <= sync_ctl_reg;
      end else if (hit(reg_addr, odsc_pkg::ADDR_SYNC_STATUS)) begin
        rdata_reg <= {4'h0, lock_sync_reg, sif.synced};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Pins come from outside the clock domain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_meta_reg <= 3'h0;
      lock_sync_reg <= 3'h0;
      mute_meta_reg <= 1'b0;
      mute_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= {freq_lock_pin, phase_lock_pin, analog_output_pll_lock_pin};
      lock_sync_reg <= lock_meta_reg;
      mute_meta_reg <= mute_req;
      mute_sync_reg <= mute_meta_reg;
    end
  end

  assign sif.autosync_mode = sync_ctl_reg[odsc_pkg::BIT_AUTOSYNC_HI:odsc_pkg::BIT_AUTOSYNC_LO];
  assign sif.manual_cmd = manual_cmd_reg;
  assign sif.analog_output_pll_lock = lock_sync_reg[0];
  assign sif.phase_lock = lock_sync_reg[1];
  assign sif.freq_lock = lock_sync_reg[2];

  odsc_sync_engine u_engine (
    .sys_clk(sys_clk),
    .rst(rst),
    .sif(sif)
  );

  assign bypass = drv_cfg_reg[odsc_pkg::BIT_BYPASS_MUTE_RETIME];
  assign system_clock_source_mask = sec_path_reg[odsc_pkg::BIT_SYSTEM_CLOCK_SOURCE_SYNC_MASK];

  // Retiming holds a mute change until it has been stable, trading latency for no runts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mute_cnt_reg <= 8'h00;
      mute_retimed_reg <= 1'b0;
    end else if (mute_sync_reg == mute_retimed_reg) begin
      mute_cnt_reg <= 8'h00;
    end else if (mute_cnt_reg >= 8'(RETIME_CYCLES - 1)) begin
      mute_cnt_reg <= 8'h00;
      mute_retimed_reg <= mute_sync_reg;
    end else begin
      mute_cnt_reg <= mute_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mute_out_reg <= 1'b0;
    end else begin
      mute_out_reg <= bypass ? mute_sync_reg : mute_retimed_reg;
    end
  end

  // Distribution state: drivers idle until first sync
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      odsc_pkg::ODSC_ST_IDLE: state_next = odsc_pkg::ODSC_ST_ARMED;
      odsc_pkg::ODSC_ST_ARMED: if (sif.sync_event) state_next = odsc_pkg::ODSC_ST_RUN;
      odsc_pkg::ODSC_ST_RUN: state_next = odsc_pkg::ODSC_ST_RUN;
      default: state_next = odsc_pkg::ODSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= odsc_pkg::ODSC_ST_IDLE;
      en_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      en_out_reg <= (state_next == odsc_pkg::ODSC_ST_RUN);
    end
  end

  // Driver configuration outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hcsl_reg <= 1'b0;
      cur_reg <= 2'h0;
      mode_reg <= 2'h0;
      divb_en_reg <= 1'b0;
      divbb_en_reg <= 1'b0;
    end else begin
      hcsl_reg <= drv_cfg_reg[odsc_pkg::BIT_HCSL_ENABLE];
      cur_reg <= drv_cfg_reg[odsc_pkg::BIT_DRIVE_CURRENT_HI:odsc_pkg::BIT_DRIVE_CURRENT_LO];
      mode_reg <= drv_cfg_reg[odsc_pkg::BIT_DRIVER_MODE_HI:odsc_pkg::BIT_DRIVER_MODE_LO];
      divb_en_reg <= 1'b1;
      divbb_en_reg <= drv_cfg_reg[odsc_pkg::BIT_DRIVER_MODE_HI:odsc_pkg::BIT_DRIVER_MODE_LO]
        == odsc_pkg::ODSC_MODE_SE_TWO_DIV;
    end
  end

  // Clock path, reference sync and masked divider sync
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sela_reg <= 1'b0;
      selb_reg <= 1'b0;
      refsync_reg <= 1'b0;
      synca_reg <= 1'b0;
      syncb_reg <= 1'b0;
    end else begin
      sela_reg <= sec_path_reg[odsc_pkg::BIT_SYSTEM_CLOCK_SOURCE_TO_DIV_A];
      selb_reg <= sec_path_reg[odsc_pkg::BIT_SYSTEM_CLOCK_SOURCE_TO_DIV_B];
      refsync_reg <= sync_ctl_reg[odsc_pkg::BIT_REF_SYNC_ENABLE];
      synca_reg <= sif.sync_event && !(system_clock_source_mask && div_a_is_system_clock_source);
      syncb_reg <= sif.sync_event && !(system_clock_source_mask && div_b_is_system_clock_source);
    end
  end

  assign reg_rdata = rdata_reg;
  assign chan1_driver_b_output_mute = mute_out_reg;
  assign chan1_driver_b_output_enable = en_out_reg;
  assign chan1_driver_b_output_hcsl = hcsl_reg;
  assign chan1_driver_b_output_current = cur_reg;
  assign chan1_driver_b_output_mode = mode_reg;
  assign chan1_divider_b_enable = divb_en_reg;
  assign chan1_divider_b_complement_enable = divbb_en_reg;
  assign chan1_divider_a_system_clock_source_sel = sela_reg;
  assign chan1_divider_b_system_clock_source_sel = selb_reg;
  assign chan1_divider_a_sync = synca_reg;
  assign chan1_divider_b_sync = syncb_reg;
  assign channel1_digital_pll_ref_sync_en = refsync_reg;

  a_bypass_mute_fast: assert property (@(posedge sys_clk) disable iff (rst)
    bypass |=> (mute_out_reg == $past(mute_sync_reg)))
    else $error("bypass mute lagged");
  a_retimed_output: assert property (@(posedge sys_clk) disable iff (rst)
    !bypass |=> (mute_out_reg == $past(mute_retimed_reg)))
    else $error("retimed mute not used");
  a_retime_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!bypass && $changed(mute_sync_reg)) |=> (mute_retimed_reg == $past(mute_retimed_reg)))
    else $error("mute not retimed");
  a_retime_passes: assert property (@(posedge sys_clk) disable iff (rst)
    (mute_sync_reg != mute_retimed_reg && mute_cnt_reg == 8'(RETIME_CYCLES - 1))
    |=> (mute_retimed_reg == $past(mute_sync_reg)))
    else $error("stable mute not passed");
  a_two_div_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (drv_cfg_reg[4:3] == 2'h2) |=> divbb_en_reg)
    else $error("second divider off");
  a_one_div_single: assert property (@(posedge sys_clk) disable iff (rst)
    (drv_cfg_reg[4:3] != 2'h2) |=> !divbb_en_reg)
    else $error("second divider on");
  a_div_b_on: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> divb_en_reg)
    else $error("main divider off");
  a_mode_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (mode_reg == $past(drv_cfg_reg[4:3])))
    else $error("mode field lost");
  a_current_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (cur_reg == $past(drv_cfg_reg[2:1])))
    else $error("current field lost");
  a_style_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (hcsl_reg == $past(drv_cfg_reg[0])))
    else $error("style bit lost");
  a_system_clock_source_path_b: assert property (@(posedge sys_clk) disable iff (rst)
    sec_path_reg[2] |=> selb_reg)
    else $error("divider b path off");
  a_path_b_off: assert property (@(posedge sys_clk) disable iff (rst)
    !sec_path_reg[2] |=> !selb_reg)
    else $error("divider b path stuck on");
  a_system_clock_source_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    sec_path_reg[1] |=> sela_reg)
    else $error("divider a path off");
  a_path_a_off: assert property (@(posedge sys_clk) disable iff (rst)
    !sec_path_reg[1] |=> !sela_reg)
    else $error("divider a path stuck on");
  a_mask_blocks_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (system_clock_source_mask && div_b_is_system_clock_source) |=> !syncb_reg)
    else $error("masked sync passed");
  a_mask_blocks_a: assert property (@(posedge sys_clk) disable iff (rst)
    (system_clock_source_mask && div_a_is_system_clock_source) |=> !synca_reg)
    else $error("masked sync passed on a");
  a_unmasked_b_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (sif.sync_event && !div_b_is_system_clock_source) |=> syncb_reg)
    else $error("unmasked divider missed sync");
  a_ref_sync_follow: assert property (@(posedge sys_clk) disable iff (rst)
    sync_ctl_reg[2] |=> refsync_reg)
    else $error("ref sync off");
  a_ref_sync_off: assert property (@(posedge sys_clk) disable iff (rst)
    !sync_ctl_reg[2] |=> !refsync_reg)
    else $error("ref sync stuck on");
  a_static_until_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (!sif.synced && !sif.sync_event) |=> !en_out_reg)
    else $error("driver ran early");
  a_enable_after_sync: assert property (@(posedge sys_clk) disable iff (rst)
    sif.sync_event |=> en_out_reg)
    else $error("driver still static after sync");
  a_enable_latched: assert property (@(posedge sys_clk) disable iff (rst)
    en_out_reg |=> en_out_reg)
    else $error("driver stopped after sync");
  a_manual_cmd_set: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == odsc_pkg::ADDR_SYNC_COMMAND && reg_wdata[odsc_pkg::BIT_SYNC_CMD])
    |=> manual_cmd_reg)
    else $error("sync command lost");
  a_manual_event: assert property (@(posedge sys_clk) disable iff (rst)
    manual_cmd_reg |=> sif.sync_event)
    else $error("manual command gave no event");
  a_manual_sync_runs: assert property (@(posedge sys_clk) disable iff (rst)
    manual_cmd_reg |-> ##[1:3] en_out_reg)
    else $error("manual sync failed");
  a_sync_both_div: assert property (@(posedge sys_clk) disable iff (rst)
    (sif.sync_event && !system_clock_source_mask) |=> (synca_reg && syncb_reg))
    else $error("dividers not synced together");
  a_idle_no_sync: assert property (@(posedge sys_clk) disable iff (rst)
    !sif.sync_event |=> (!synca_reg && !syncb_reg))
    else $error("divider sync without event");
  a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> (rdata_reg == 8'h00))
    else $error("read data outside read cycle");
  a_drv_cfg_read: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == odsc_pkg::ADDR_DRIVER_B_CONFIG)
    |=> (rdata_reg == $past(drv_cfg_reg)))
    else $error("driver config read wrong");
  a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == odsc_pkg::ADDR_SYNC_STATUS)
    |=> (rdata_reg[0] == $past(sif.synced)))
    else $error("synced status read wrong");
endmodule

/* File: odsc_top_bench.sv */
// Self-checking bench for the driver B configuration and sync control block
`timescale 1ns/1ps
module odsc_top_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic mute_req = 1'b0;
  logic [2:0] lock_pins = 3'h0;
  logic div_a_is_system_clock_source = 1'b0;
  logic div_b_is_system_clock_source = 1'b0;
  logic mute_o, enable_o, hcsl_o, div_b_en_o, div_bb_en_o, sel_a_o, sel_b_o;
  logic sync_a_o, sync_b_o, ref_en_o;
  logic [1:0] current_o, mode_o;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int cnt_a = 0;
  int cnt_b = 0;
  logic [7:0] rv;

  always #50 sys_clk = ~sys_clk;

  odsc_top odsc_top_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mute_req(mute_req),
    .analog_output_pll_lock_pin(lock_pins[0]), .phase_lock_pin(lock_pins[1]),
    .freq_lock_pin(lock_pins[2]), .div_a_is_system_clock_source(div_a_is_system_clock_source),
    .div_b_is_system_clock_source(div_b_is_system_clock_source), .chan1_driver_b_output_mute(mute_o),
    .chan1_driver_b_output_enable(enable_o), .chan1_driver_b_output_hcsl(hcsl_o),
    .chan1_driver_b_output_current(current_o), .chan1_driver_b_output_mode(mode_o),
    .chan1_divider_b_enable(div_b_en_o), .chan1_divider_b_complement_enable(div_bb_en_o),
    .chan1_divider_a_system_clock_source_sel(sel_a_o), .chan1_divider_b_system_clock_source_sel(sel_b_o),
    .chan1_divider_a_sync(sync_a_o), .chan1_divider_b_sync(sync_b_o),
    .channel1_digital_pll_ref_sync_en(ref_en_o)
  );

  // Pulse counters let scenarios compare sync counts over a window
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (sync_a_o === 1'b1) cnt_a <= cnt_a + 1;
    if (sync_b_o === 1'b1) cnt_b <= cnt_b + 1;
    if (cycles == 4000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic manual_sync(input int exp_a, input int exp_b);
    int a0;
    int b0;
    a0 = cnt_a;
    b0 = cnt_b;
    wr(odsc_pkg::ADDR_SYNC_COMMAND, 8'h01);
    wait_cycles(8);
    check(8'(cnt_a - a0), 8'(exp_a));
    check(8'(cnt_b - b0), 8'(exp_b));
  endtask

  initial begin
    int a0;
    int b0;
    int hits;
    logic [7:0] v;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(odsc_pkg::ADDR_DRIVER_B_CONFIG, rv);
    check(rv, odsc_pkg::RESET_DRIVER_B_CONFIG);
    rd(odsc_pkg::ADDR_SECONDARY_CLOCK_PATH, rv);
    check(rv, odsc_pkg::RESET_SECONDARY_CLOCK_PATH);
    rd(odsc_pkg::ADDR_SYNC_CONTROL, rv);
    check(rv, odsc_pkg::RESET_SYNC_CONTROL);
    check(8'(enable_o), 8'h00);
    wr(16'h14DA, 8'hFF);
    rd(16'h14DA, rv);
    check(rv, 8'h00);
    rd(odsc_pkg::ADDR_SYNC_COMMAND, rv);
    check(rv, 8'h00);
    // Every mode and current code, HCSL toggled along the way
    for (int md = 0; md < 3; md++) begin
      for (int cur = 0; cur < 3; cur++) begin
        v = {3'h0, 2'(md), 2'(cur), 1'(cur)};
        wr(odsc_pkg::ADDR_DRIVER_B_CONFIG, v);
        rd(odsc_pkg::ADDR_DRIVER_B_CONFIG, rv);
        check(rv, v);
        check(8'(mode_o), 8'(md));
        check(8'(div_bb_en_o), 8'(md == 2));
        check(8'(div_b_en_o), 8'h01);
        check(8'(current_o), 8'(cur));
        check(8'(hcsl_o), 8'(cur % 2));
      end
    end
    wr(odsc_pkg::ADDR_DRIVER_B_CONFIG, 8'hFF);
    rd(odsc_pkg::ADDR_DRIVER_B_CONFIG, rv);
    check(rv, 8'h3F);
    for (int p = 0; p < 4; p++) begin
      v = 8'(p << 1);
      wr(odsc_pkg::ADDR_SECONDARY_CLOCK_PATH, v);
      rd(odsc_pkg::ADDR_SECONDARY_CLOCK_PATH, rv);
      check(rv, v);
      check(8'(sel_a_o), 8'(p % 2));
      check(8'(sel_b_o), 8'(p / 2));
    end
    wr(odsc_pkg::ADDR_SECONDARY_CLOCK_PATH, 8'h00);
    // Pins are dropped before each mode change so a held lock cannot pose as an edge
    for (int m = 0; m < 4; m++) begin
      lock_pins <= 3'h0;
      wait_cycles(6);
      v = {5'h00, 1'(m), 2'(m)};
      wr(odsc_pkg::ADDR_SYNC_CONTROL, v);
      rd(odsc_pkg::ADDR_SYNC_CONTROL, rv);
      check(rv, v);
      check(8'(ref_en_o), 8'(m % 2));
      for (int p = 0; p < 3; p++) begin
        a0 = cnt_a;
        b0 = cnt_b;
        @(posedge sys_clk);
        lock_pins[p] <= 1'b1;
        wait_cycles(12);
        check(8'(cnt_b - b0), 8'(m == p + 1));
        check(8'(cnt_a - a0), 8'(m == p + 1));
      end
      if (m == 0) check(8'(enable_o), 8'h00);
    end
    check(8'(enable_o), 8'h01);
    lock_pins <= 3'h0;
    wait_cycles(6);
    rd(odsc_pkg::ADDR_SYNC_STATUS, rv);
    check(rv, 8'h01);
    wr(odsc_pkg::ADDR_SYNC_CONTROL, 8'h00);
    manual_sync(1, 1);
    div_a_is_system_clock_source <= 1'b1;
    // Mask goes on only now, long after the clock paths were set up and left alone
    wr(odsc_pkg::ADDR_SECONDARY_CLOCK_PATH, 8'h01);
    manual_sync(0, 1);
    div_b_is_system_clock_source <= 1'b1;
    manual_sync(0, 0);
    // Bypass: the mute follows the pin after the two-flop synchroniser
    wr(odsc_pkg::ADDR_DRIVER_B_CONFIG, 8'h20);
    @(posedge sys_clk);
    mute_req <= 1'b1;
    wait_cycles(2);
    check(8'(mute_o), 8'h00);
    wait_cycles(2);
    check(8'(mute_o), 8'h01);
    mute_req <= 1'b0;
    wr(odsc_pkg::ADDR_DRIVER_B_CONFIG, 8'h00);
    wait_cycles(8);
    // Retimed: a one-cycle request is too short to pass
    hits = 0;
    mute_req <= 1'b1;
    @(posedge sys_clk);
    mute_req <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      wait_cycles(1);
      if (mute_o === 1'b1) hits++;
    end
    check(8'(hits), 8'h00);
    @(posedge sys_clk);
    mute_req <= 1'b1;
    wait_cycles(8);
    check(8'(mute_o), 8'h01);
    report_and_stop();
  end
endmodule
